//--- hdl/csc_clock_ctrl.sv
// Clock source decode, reset time-out, oscillator start-up count,
// divide-by-eight prescaler and per-domain clock enables.
// Assumes one 10 MHz system clock; oscillator and watchdog clocks arrive
// as slow asynchronous pins and are only sampled, never used as clocks.
//
// Overview of operation
// [RQ1] Four-bit source-select field picks crystal, RC, external clock or reserved code.
// [RQ2] Every fuse bit: one means unprogrammed, zero means programmed.
// [RQ3] Factory default: calibrated RC, start-up 10, divide-by-eight programmed.
// [RQ4] Internal reset stays on for a time-out after other resets release.
// [RQ5] Time-out counts watchdog cycles: 0, 512 or 8192, chosen by fuses.
// [RQ6] Ripple counter on oscillator holds reset for start-up count, then releases.
// [RQ7] Start-up count depends on clock type, 6 up to 32K cycles.
// [RQ8] Reset start applies time-out and start-up; power-save/down wake only start-up.
// [RQ9] Zero time-out option exists, meant for use with brown-out detection.
// [RQ10] Core clock feeds register file and stack; halting it stops the core.
// [RQ11] Peripheral clock drives timers and ports; some interrupts detected when halted.
// [RQ12] Serial start and two-wire address detected asynchronously in sleep.
// [RQ13] Flash interface clock runs together with the core clock.
// [RQ14] Asynchronous timer clock keeps running in sleep for real-time counting.
// [RQ15] Converter has its own clock so core and peripheral clocks may halt.
// [RQ16] Unused domains are gated off according to sleep mode.
// [RQ17] Low-power crystal: lowest select bit and start-up bits pick 258 to 16K.
// [RQ18] Start-up counter restarts from zero on reset release and every wake; only power-down and power-save wakes run start-up, others go straight to run.
`timescale 1ns/1ps
`default_nettype none
module csc_clock_ctrl #(
  parameter logic [15:0] P_TOUT_LONG = csc_pkg::C_TOUT_LONG,
  parameter logic [15:0] P_SU_16K = csc_pkg::C_SU_16K,
  parameter logic [15:0] P_SU_32K = csc_pkg::C_SU_32K
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire csc_pkg::csc_fuse_t i_fuse,
  input wire logic i_other_reset,
  input wire logic i_wdt_osc_clk,
  input wire logic i_osc_clk,
  input wire logic i_ext_int_pin,
  input wire logic i_usi_start_pin,
  input wire logic i_twi_addr_match,
  input wire logic i_sleep_req,
  input wire csc_pkg::csc_sleep_t i_sleep_mode,
  input wire logic i_wake_req,
  output logic o_internal_reset,
  output csc_pkg::csc_gate_t o_gate,
  output csc_pkg::csc_src_t o_source,
  output logic o_source_reserved,
  output logic o_async_wake
);

  csc_pkg::csc_regs_t r;
  csc_pkg::csc_regs_t n;
  logic [csc_pkg::C_NPINS-1:0] pin_vec;
  logic [csc_pkg::C_NPINS-1:0] pin_rise;
  logic [15:0] tout_target;
  logic [15:0] su_target;
  logic sys_tick;
  logic wake;
  logic pin_wake;
  csc_pkg::csc_gate_t on;

  // Every asynchronous pin passes the same two-flop synchroniser
  assign pin_vec = {i_twi_addr_match, i_usi_start_pin, i_ext_int_pin, i_osc_clk, i_wdt_osc_clk};
  for (genvar g = 0; g < csc_pkg::C_NPINS; g++) begin : g_sync
    csc_pin_sync u_sync (
      .i_mclk(i_mclk),
      .i_resetn(i_resetn),
      .i_pin(pin_vec[g]),
      .o_rise(pin_rise[g])
    );
  end

  // Source decode from the select field
  function automatic csc_pkg::csc_src_t src_of(logic [3:0] s);
    if (s >= csc_pkg::C_SRC_LP_MIN) return csc_pkg::SRC_LP_XTAL; // RQ1
    else if (s >= csc_pkg::C_SRC_FS_MIN) return csc_pkg::SRC_FS_XTAL;
    else if (s >= csc_pkg::C_SRC_LF_MIN) return csc_pkg::SRC_LF_XTAL;
    else if (s == csc_pkg::C_SRC_RC128) return csc_pkg::SRC_RC128;
    else if (s == csc_pkg::C_SRC_RCCAL) return csc_pkg::SRC_RC_CAL;
    else if (s == csc_pkg::C_SRC_EXT) return csc_pkg::SRC_EXT;
    else return csc_pkg::SRC_RSVD;
  endfunction

  // Time-out length; LP and FS crystals use select bit 0 with the start-up bits
  function automatic logic [15:0] tout_of(csc_pkg::csc_fuse_t f);
    logic [2:0] k;
    csc_pkg::csc_src_t s;
    k = {f.clock_source_select[0], f.startup_time_select};
    s = src_of(f.clock_source_select);
    if (s == csc_pkg::SRC_LP_XTAL || s == csc_pkg::SRC_FS_XTAL) begin
      case (k)
        3'h2, 3'h5: return csc_pkg::C_TOUT_NONE; // RQ9
        3'h0, 3'h3, 3'h6: return csc_pkg::C_TOUT_SHORT; // RQ5
        default: return P_TOUT_LONG;
      endcase
    end else begin
      case (f.startup_time_select)
        2'h0: return csc_pkg::C_TOUT_NONE; // RQ9
        2'h1: return csc_pkg::C_TOUT_SHORT;
        default: return P_TOUT_LONG; // RQ5
      endcase
    end
  endfunction

  // Oscillator start-up length by clock type
  function automatic logic [15:0] su_of(csc_pkg::csc_fuse_t f);
    logic [2:0] k;
    csc_pkg::csc_src_t s;
    k = {f.clock_source_select[0], f.startup_time_select};
    s = src_of(f.clock_source_select);
    if (s == csc_pkg::SRC_LP_XTAL || s == csc_pkg::SRC_FS_XTAL) begin
      case (k)
        3'h0, 3'h1: return csc_pkg::C_SU_258; // RQ17
        3'h2, 3'h3, 3'h4: return csc_pkg::C_SU_1K;
        default: return P_SU_16K;
      endcase
    end else if (s == csc_pkg::SRC_LF_XTAL) begin
      return P_SU_32K; // RQ7
    end else begin
      return csc_pkg::C_SU_EXT;
    end
  endfunction

  assign tout_target = tout_of(r.fuse);
  // The extra cycles apply only when starting from reset
  assign su_target = r.from_reset ? 16'(su_of(r.fuse) + csc_pkg::C_RESET_EXTRA_CK)
                                  : su_of(r.fuse);

  // Prescaler tick; an unprogrammed fuse lets every cycle through
  assign sys_tick = (r.fuse.divide_by_eight_fuse == csc_pkg::C_PROGRAMMED) ?
                    (r.div == csc_pkg::C_DIV8_LAST) : 1'b1; // RQ2

  // Asynchronously detected pins still wake the part while clocks are gated
  assign pin_wake = pin_rise[csc_pkg::C_PIN_EXTINT] | pin_rise[csc_pkg::C_PIN_USI] |
                    pin_rise[csc_pkg::C_PIN_TWI]; // RQ11 RQ12
  assign wake = pin_wake | i_wake_req;

  // Which domains run, by state and sleep mode
  always_comb begin
    on = '0;
    if (r.state == csc_pkg::ST_RUN) begin
      on = '1; // RQ10 RQ13
    end else if (r.state == csc_pkg::ST_SLEEP) begin
      case (r.mode)
        csc_pkg::SLP_IDLE: begin
          on.peripheral_clock = 1'b1;
          on.async_timer_clock = 1'b1;
          on.converter_clock = 1'b1;
        end
        csc_pkg::SLP_CONV: begin
          on.async_timer_clock = 1'b1; // RQ14
          on.converter_clock = 1'b1; // RQ15
        end
        csc_pkg::SLP_PSAVE, csc_pkg::SLP_XSTBY: begin
          on.async_timer_clock = 1'b1; // RQ14
        end
        default: on = '0; // RQ16
      endcase
    end
  end

  // Next-state logic for the whole controller
  always_comb begin
    n = r;
    n.async_wake = 1'b0;
    n.div = (r.fuse.divide_by_eight_fuse == csc_pkg::C_PROGRAMMED) ? 3'(r.div + 3'h1) : 3'h0;
    n.src = src_of(r.fuse.clock_source_select);
    n.reserved = (n.src == csc_pkg::SRC_RSVD);
    case (r.state)
      csc_pkg::ST_RESET: begin
        // Fuses are read while held in reset
        n.fuse = i_fuse;
        n.cnt = 16'h0000; // RQ18
        n.from_reset = 1'b1;
        if (!i_other_reset && !r.reserved) begin
          n.state = (tout_target == csc_pkg::C_TOUT_NONE) ? csc_pkg::ST_STARTUP
                                                          : csc_pkg::ST_TIMEOUT; // RQ4 RQ9
        end
      end
      csc_pkg::ST_TIMEOUT: begin
        if (pin_rise[csc_pkg::C_PIN_WDT]) begin
          if (r.cnt == 16'(tout_target - 16'h0001)) begin
            n.state = csc_pkg::ST_STARTUP; // RQ5
            n.cnt = 16'h0000; // RQ18
          end else begin
            n.cnt = 16'(r.cnt + 16'h0001);
          end
        end
      end
      csc_pkg::ST_STARTUP: begin
        if (pin_rise[csc_pkg::C_PIN_OSC]) begin
          if (r.cnt == 16'(su_target - 16'h0001)) begin
            n.state = csc_pkg::ST_RUN; // RQ6
            n.cnt = 16'h0000;
          end else begin
            n.cnt = 16'(r.cnt + 16'h0001);
          end
        end
      end
      csc_pkg::ST_RUN: begin
        if (i_sleep_req) begin
          n.mode = i_sleep_mode;
          n.state = csc_pkg::ST_SLEEP;
        end
      end
      csc_pkg::ST_SLEEP: begin
        n.async_wake = pin_wake;
        if (wake) begin
          // Only the deep modes stop the oscillator and need a fresh start-up
          if (r.mode == csc_pkg::SLP_PDOWN || r.mode == csc_pkg::SLP_PSAVE) begin
            n.state = csc_pkg::ST_STARTUP; // RQ8
            n.cnt = 16'h0000; // RQ18
            n.from_reset = 1'b0;
          end else begin
            n.state = csc_pkg::ST_RUN;
          end
        end
      end
      default: n.state = csc_pkg::ST_RESET;
    endcase
    if (i_other_reset) begin
      n.state = csc_pkg::ST_RESET;
    end
    n.int_reset = (n.state == csc_pkg::ST_RESET) || (n.state == csc_pkg::ST_TIMEOUT) ||
                  (n.state == csc_pkg::ST_STARTUP && n.from_reset); // RQ4 RQ6
    n.gate = on & {5{sys_tick}}; // RQ3 RQ16
  end

  // Register the state; fuse latch resets to the factory default
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      r <= '0;
      r.state <= csc_pkg::ST_RESET;
      r.fuse <= '{csc_pkg::C_DEF_SRC, csc_pkg::C_DEF_SUT, csc_pkg::C_DEF_DIV8}; // RQ3
      r.mode <= csc_pkg::SLP_IDLE;
      r.src <= csc_pkg::SRC_RC_CAL;
      r.from_reset <= 1'b1;
      r.int_reset <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign o_internal_reset = r.int_reset;
  assign o_gate = r.gate;
  assign o_source = r.src;
  assign o_source_reserved = r.reserved;
  assign o_async_wake = r.async_wake;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  hold_reset_a: assert property (i_other_reset |=> o_internal_reset) // RQ4
    else $error("internal reset not held during other reset");

  tout_end_a: assert property ( // RQ5
    (r.state == csc_pkg::ST_TIMEOUT && !i_other_reset &&
    pin_rise[csc_pkg::C_PIN_WDT] && r.cnt == 16'(tout_target - 16'h0001))
    |=> r.state == csc_pkg::ST_STARTUP && r.cnt == 16'h0000)
    else $error("time-out did not end at its count");

  startup_end_a: assert property ( // RQ6
    (r.state == csc_pkg::ST_STARTUP && !i_other_reset &&
    pin_rise[csc_pkg::C_PIN_OSC] && r.cnt == 16'(su_target - 16'h0001))
    |=> r.state == csc_pkg::ST_RUN && !o_internal_reset)
    else $error("start-up count did not release reset");

  // Run is never reached before the full start-up count
  run_count_a: assert property ( // RQ7
    (r.state == csc_pkg::ST_RUN && $past(r.state) == csc_pkg::ST_STARTUP)
    |-> $past(r.cnt) == 16'(su_target - 16'h0001))
    else $error("start-up ended before its count");

  zero_tout_a: assert property ( // RQ9
    (r.state == csc_pkg::ST_RESET && !i_other_reset &&
    !r.reserved && tout_target == csc_pkg::C_TOUT_NONE)
    |=> r.state == csc_pkg::ST_STARTUP)
    else $error("zero time-out still entered time-out");

  wake_path_a: assert property ( // RQ8
    (r.state == csc_pkg::ST_SLEEP && wake && !i_other_reset &&
    r.mode == csc_pkg::SLP_PDOWN) |=> r.state == csc_pkg::ST_STARTUP && r.cnt == 16'h0000
    && !o_internal_reset)
    else $error("power-down wake took the wrong path");

  // The wake flag only follows a pin event seen while asleep
  wake_flag_a: assert property ( // RQ12
    o_async_wake |-> $past(r.state) == csc_pkg::ST_SLEEP && $past(pin_wake))
    else $error("wake flag without a pin wake in sleep");

  nvm_core_a: assert property (o_gate.nvm_interface_clock == o_gate.core_clock) // RQ13
    else $error("flash clock not tied to core clock");

  // Fuses only change in reset, so a fresh latch must not count as a rate error
  div_rate_a: assert property ( // RQ2
    disable iff (!i_resetn || r.state == csc_pkg::ST_RESET)
    (r.fuse.divide_by_eight_fuse == csc_pkg::C_PROGRAMMED && sys_tick && $stable(r.fuse))
    |=> !sys_tick [*7] ##1 sys_tick)
    else $error("prescaler tick not every eighth cycle");

  core_gate_a: assert property (o_gate.core_clock |-> $past(r.state) == csc_pkg::ST_RUN) // RQ10
    else $error("core clock ran outside run state");

  conv_sleep_a: assert property ( // RQ15
    (r.state == csc_pkg::ST_SLEEP && r.mode == csc_pkg::SLP_CONV)
    |=> !o_gate.peripheral_clock && !o_gate.core_clock)
    else $error("clocks not halted in converter sleep");

endmodule
`default_nettype wire

//--- hdl/csc_pin_sync.sv
// Two-stage synchroniser with rising-edge detect for one asynchronous input.
// Assumes the input toggles slower than half the system clock rate.
`timescale 1ns/1ps
`default_nettype none
module csc_pin_sync (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_pin,
  output logic o_rise
);

  csc_pkg::csc_sync_t r;
  csc_pkg::csc_sync_t n;

  // Only the second stage feeds the edge detector; meta stays private
  always_comb begin
    n = r;
    n.meta = i_pin;
    n.level = r.meta;
    n.last = r.level;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign o_rise = r.level & ~r.last;

endmodule
`default_nettype wire

//--- hdl/csc_pkg.sv
// Package for the clock source and start-up controller: fuse codes,
// cycle counts, state and sleep-mode types, and the carriers.
// Assumes a single system clock; all counts but the prescaler's are in ticks of slower clocks.
package csc_pkg;

  // Fuse polarity: a programmed fuse reads as zero
  localparam logic C_PROGRAMMED = 1'b0;

  // Source-select codes
  localparam logic [3:0] C_SRC_LP_MIN = 4'h8;
  localparam logic [3:0] C_SRC_FS_MIN = 4'h6;
  localparam logic [3:0] C_SRC_LF_MIN = 4'h4;
  localparam logic [3:0] C_SRC_RC128 = 4'h3;
  localparam logic [3:0] C_SRC_RCCAL = 4'h2;
  localparam logic [3:0] C_SRC_RSVD = 4'h1;
  localparam logic [3:0] C_SRC_EXT = 4'h0;

  // Factory default fuse setting
  localparam logic [3:0] C_DEF_SRC = 4'h2;
  localparam logic [1:0] C_DEF_SUT = 2'h2;
  localparam logic C_DEF_DIV8 = 1'b0;

  // Time-out lengths in watchdog oscillator cycles
  localparam logic [15:0] C_TOUT_NONE = 16'h0000;
  localparam logic [15:0] C_TOUT_SHORT = 16'h0200;
  localparam logic [15:0] C_TOUT_LONG = 16'h2000;

  // Oscillator start-up lengths in oscillator cycles
  localparam logic [15:0] C_SU_EXT = 16'h0006;
  localparam logic [15:0] C_SU_258 = 16'h0102;
  localparam logic [15:0] C_SU_1K = 16'h0400;
  localparam logic [15:0] C_SU_16K = 16'h4000;
  localparam logic [15:0] C_SU_32K = 16'h8000;
  localparam logic [15:0] C_RESET_EXTRA_CK = 16'h000e;

  // Divide-by-eight prescaler
  localparam logic [2:0] C_DIV8_LAST = 3'h7;

  // Asynchronous pin inputs, by index
  localparam int C_NPINS = 5;
  localparam int C_PIN_WDT = 0;
  localparam int C_PIN_OSC = 1;
  localparam int C_PIN_EXTINT = 2;
  localparam int C_PIN_USI = 3;
  localparam int C_PIN_TWI = 4;

  typedef enum logic [2:0] {
    SLP_IDLE, SLP_CONV, SLP_PDOWN, SLP_PSAVE, SLP_STBY, SLP_XSTBY
  } csc_sleep_t;

  typedef enum logic [2:0] {
    ST_RESET, ST_TIMEOUT, ST_STARTUP, ST_RUN, ST_SLEEP
  } csc_state_t;

  typedef enum logic [2:0] {
    SRC_LP_XTAL, SRC_FS_XTAL, SRC_LF_XTAL, SRC_RC128, SRC_RC_CAL, SRC_EXT, SRC_RSVD
  } csc_src_t;

  typedef struct packed {
    logic [3:0] clock_source_select;
    logic [1:0] startup_time_select;
    logic divide_by_eight_fuse;
  } csc_fuse_t;

  // Clock-domain enables, one bit per domain
  typedef struct packed {
    logic core_clock;
    logic peripheral_clock;
    logic nvm_interface_clock;
    logic async_timer_clock;
    logic converter_clock;
  } csc_gate_t;

  typedef struct packed {
    logic meta;
    logic level;
    logic last;
  } csc_sync_t;

  typedef struct packed {
    csc_state_t state;
    csc_fuse_t fuse;
    csc_sleep_t mode;
    logic [15:0] cnt;
    logic from_reset;
    logic [2:0] div;
    csc_gate_t gate;
    logic int_reset;
    logic async_wake;
    csc_src_t src;
    logic reserved;
  } csc_regs_t;

endpackage

//--- test/csc_clock_ctrl_tb.sv
// Self-checking bench for the clock source and start-up controller.
// Assumes shortened long counts and two gated slow oscillator models.
`timescale 1ns/1ps
`default_nettype none
module csc_clock_ctrl_tb;
  localparam logic [15:0] TL = 16'h0010;
  localparam logic [15:0] S16 = 16'h0014;
  localparam logic [15:0] S32 = 16'h0018;
  logic i_mclk = 1'b0;
  logic i_resetn = 1'b0;
  csc_pkg::csc_fuse_t fuse = 7'h14;
  logic orst = 1'b1, slp = 1'b0, wake = 1'b0, wgo = 1'b0, ogo = 1'b0;
  logic [2:0] pin = 3'h0;
  csc_pkg::csc_sleep_t mode = csc_pkg::SLP_IDLE;
  logic wclk, oclk, ireset, rsvd, awake;
  logic [15:0] wrise, orise;
  csc_pkg::csc_gate_t gate;
  csc_pkg::csc_src_t src;
  int failures = 0;
  int checks = 0;
  int seed = 28;

  // 10 MHz system clock
  always #50 i_mclk = ~i_mclk;

  csc_clock_ctrl #(.P_TOUT_LONG(TL), .P_SU_16K(S16), .P_SU_32K(S32)) dut (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_fuse(fuse), .i_other_reset(orst),
    .i_wdt_osc_clk(wclk), .i_osc_clk(oclk), .i_ext_int_pin(pin[0]),
    .i_usi_start_pin(pin[1]), .i_twi_addr_match(pin[2]), .i_sleep_req(slp),
    .i_sleep_mode(mode), .i_wake_req(wake), .o_internal_reset(ireset), .o_gate(gate),
    .o_source(src), .o_source_reserved(rsvd), .o_async_wake(awake));
  csc_osc_model #(.P_HALF(3)) wdt_m (.i_mclk(i_mclk), .i_go(wgo), .o_clk(wclk),
    .o_rises(wrise));
  csc_osc_model #(.P_HALF(3)) osc_m (.i_mclk(i_mclk), .i_go(ogo), .o_clk(oclk),
    .o_rises(orise));

  // Expected source decode
  function automatic csc_pkg::csc_src_t src_of(input logic [3:0] c);
    if (c >= 4'h8) return csc_pkg::SRC_LP_XTAL;
    if (c >= 4'h6) return csc_pkg::SRC_FS_XTAL;
    if (c >= 4'h4) return csc_pkg::SRC_LF_XTAL;
    if (c == 4'h3) return csc_pkg::SRC_RC128;
    if (c == 4'h2) return csc_pkg::SRC_RC_CAL;
    if (c == 4'h1) return csc_pkg::SRC_RSVD;
    return csc_pkg::SRC_EXT;
  endfunction

  // Expected time-out in watchdog cycles
  function automatic int tout_of(input csc_pkg::csc_fuse_t f);
    logic [2:0] ix;
    ix = {f.clock_source_select[0], f.startup_time_select};
    if (f.clock_source_select >= 4'h6) begin
      if (ix == 3'h2 || ix == 3'h5) return 0;
      if (ix == 3'h0 || ix == 3'h3 || ix == 3'h6) return 512;
      return int'(TL);
    end
    if (f.startup_time_select == 2'h0) return 0;
    if (f.startup_time_select == 2'h1) return 512;
    return int'(TL);
  endfunction

  // Expected start-up count in oscillator cycles; 14 more after a reset
  function automatic int su_of(input csc_pkg::csc_fuse_t f, input bit rst);
    logic [2:0] ix;
    int s;
    ix = {f.clock_source_select[0], f.startup_time_select};
    if (f.clock_source_select >= 4'h6) s = (ix < 2) ? 258 : (ix < 5) ? 1024 : int'(S16);
    else if (f.clock_source_select[3:1] == 3'h2) s = int'(S32);
    else s = 6;
    return rst ? s + 14 : s;
  endfunction

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
  endtask

  // Run one oscillator for exactly n rising edges, then let it rest low
  task automatic emit(input bit osc, input int n);
    int base;
    int k;
    base = osc ? int'(orise) : int'(wrise);
    k = 0;
    if (n > 0) begin
      if (osc) begin
        ogo <= 1'b1;
      end else begin
        wgo <= 1'b1;
      end
      while ((osc ? int'(orise) : int'(wrise)) != base + n && k < 20000) begin
        cyc(1);
        k++;
      end
      ogo <= 1'b0;
      wgo <= 1'b0;
      cyc(8);
    end
  endtask

  // OR of the domain enables over eight cycles covers both prescaler settings
  task automatic gate_or(output logic [4:0] g);
    g = 5'h00;
    repeat (8) begin
      cyc(1);
      g = g | gate;
    end
  endtask

  // Core clock pulses seen over sixteen cycles in run
  task automatic pulses(output int c);
    c = 0;
    repeat (16) begin
      cyc(1);
      c += int'(gate.core_clock);
    end
  endtask

  // Cold start: hold the other reset, release it and feed exact edge counts
  task automatic startup(input csc_pkg::csc_fuse_t fv);
    int t;
    int s;
    t = tout_of(fv);
    s = su_of(fv, 1'b1);
    orst <= 1'b1;
    fuse <= fv;
    cyc(4);
    orst <= 1'b0;
    cyc(10);
    chk("reset_after_release", 16'(ireset), 16'h0001);
    if (t > 0) begin
      emit(1'b0, t - 1);
      chk("reset_in_timeout", 16'(ireset), 16'h0001);
      emit(1'b0, 1);
    end
    emit(1'b1, s - 1);
    chk("reset_in_startup", 16'(ireset), 16'h0001);
    emit(1'b1, 1);
    chk("reset_released", 16'(ireset), 16'h0000);
    $display("test startup fuse %h done", fv);
  endtask

  task automatic print_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    logic [4:0] g;
    logic aw;
    int np;
    csc_pkg::csc_fuse_t f;
    cyc(10);
    chk("reset_source", 16'(src), 16'(csc_pkg::SRC_RC_CAL));
    chk("reset_gates", 16'(gate), 16'h0000);
    cyc(2);
    i_resetn <= 1'b1;
    cyc(4);
    // Every source code, latched while the other reset holds the part
    for (int c = 0; c < 16; c++) begin
      fuse <= {4'(c), 2'h3, 1'b1};
      cyc(4);
      chk("source", 16'(src), 16'(src_of(4'(c))));
      chk("reserved", 16'(rsvd), 16'(c == 1));
    end
    // Release the other reset with the reserved code latched
    fuse <= {4'h1, 2'h3, 1'b1};
    cyc(4);
    orst <= 1'b0;
    cyc(20);
    chk("reserved_holds", 16'(ireset), 16'h0001);
    $display("test decode done");
    startup(7'h42);
    pulses(np);
    chk("div8_pulses", 16'(np), 16'h0002);
    startup(7'h79);
    startup(7'h24);
    startup(7'h1a);
    repeat (3) begin
      f = 7'($random(seed));
      if (f.clock_source_select == 4'h1) f.clock_source_select = 4'h2;
      startup(f);
    end
    // A start-up cut short by another reset must count again from zero
    orst <= 1'b1;
    fuse <= 7'h01;
    cyc(4);
    orst <= 1'b0;
    cyc(10);
    emit(1'b1, 10);
    chk("cut_startup_reset", 16'(ireset), 16'h0001);
    startup(7'h01);
    // Each sleep mode: gated domains, then wake by pin or request
    for (int m = 0; m < 6; m++) begin
      slp <= 1'b1;
      mode <= csc_pkg::csc_sleep_t'(3'(m));
      cyc(1);
      slp <= 1'b0;
      cyc(4);
      gate_or(g);
      chk("sleep_gates", 16'(g), (m == 0) ? 16'h000b : (m == 1) ? 16'h0003 :
        (m == 3 || m == 5) ? 16'h0002 : 16'h0000);
      if (m == 4) begin
        wake <= 1'b1;
        cyc(1);
        wake <= 1'b0;
      end else begin
        pin[m % 3] <= 1'b1;
        aw = 1'b0;
        repeat (10) begin
          cyc(1);
          aw = aw | awake;
        end
        pin <= 3'h0;
        chk("async_wake", 16'(aw), 16'h0001);
      end
      if (m == 2 || m == 3) begin
        gate_or(g);
        chk("wake_gates_off", 16'(g), 16'h0000);
        chk("wake_no_reset", 16'(ireset), 16'h0000);
        emit(1'b1, su_of(fuse, 1'b0) - 1);
        gate_or(g);
        chk("startup_gates_off", 16'(g), 16'h0000);
        emit(1'b1, 1);
      end
      cyc(4);
      gate_or(g);
      chk("run_gates", 16'(g), 16'h001f);
      $display("test sleep mode %0d done", m);
    end
    pulses(np);
    chk("undivided_pulses", 16'(np), 16'h0010);
    $display("test prescaler done");
    print_verdict();
  end

  // Watchdog sized well above the longest expected sequence
  initial begin
    repeat (90000) @(posedge i_mclk);
    failures++;
    print_verdict();
  end
endmodule
`default_nettype wire

//--- test/csc_osc_model.sv
// Behavioural model of a slow clock source: watchdog or selected oscillator.
// Assumes the bench starts and stops it; it rests low between bursts.
`timescale 1ns/1ps
`default_nettype none
module csc_osc_model #(
  parameter int P_HALF = 3
) (
  input wire logic i_mclk,
  input wire logic i_go,
  output logic o_clk,
  output logic [15:0] o_rises
);
  int ph;

  initial begin
    ph = 0;
    o_clk = 1'b0;
    o_rises = 16'h0000;
  end

  // A started high phase always completes, so a stop never leaves a runt pulse
  always @(posedge i_mclk) begin
    if (!i_go && !o_clk) begin
      ph <= 0;
    end else if (ph == P_HALF - 1) begin
      ph <= 0;
      o_clk <= !o_clk;
      if (!o_clk) begin
        o_rises <= o_rises + 16'h0001;
      end
    end else begin
      ph <= ph + 1;
    end
  end
endmodule
`default_nettype wire
